// ---- src/dacctl_top.sv ----
// Top: register port, enable decode and converter drive for the two-channel DAC control block
module dacctl_top
(
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    input  wire logic [1:0]              reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [7:0]              reg_rdata,
    input  wire logic                    standby,
    output dacctl_pkg::dacctl_chan_t     analog_out_ch0,
    output dacctl_pkg::dacctl_chan_t     analog_out_ch1,
    output logic                         module_stopped
);

    dacctl_pkg::dacctl_req_t req;
    logic [2:0] ctrl_q;
    logic       stop_q;
    logic [7:0] data0_q;
    logic [7:0] data1_q;
    logic       wrote0_q;
    logic       wrote1_q;
    logic [7:0] rdata_q;
    logic       ch0_oe;
    logic       ch1_oe;
    logic       joint;
    logic       conv0;
    logic       conv1;
    logic       wr_data0;
    logic       wr_data1;
    logic       wr_ctrl;
    logic       wr_stop;
    logic       access_ok;
    logic [7:0] ctrl_view;
    logic [7:0] rd_mux;

    // Conversion enable for one channel; one body for both so the joint rule cannot drift
    function automatic logic conv_enable
    (
        input logic own_oe,
        input logic other_oe,
        input logic joint_en
    );
        return own_oe || (joint_en && other_oe);
    endfunction

    // Write select for one register index; the stop register passes an open gate
    function automatic logic write_hit
    (
        input logic       wr_req,
        input logic       gate_ok,
        input logic [1:0] addr,
        input logic [1:0] index
    );
        return wr_req && gate_ok && (addr == index);
    endfunction

    // Bundle the port request
    assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

    // Stop register stays reachable; others gated while stopped
    assign access_ok = !stop_q;
    assign wr_data0  = write_hit(req.wr, access_ok, req.addr, dacctl_pkg::DACCTL_ADDR_DATA0);
    assign wr_data1  = write_hit(req.wr, access_ok, req.addr, dacctl_pkg::DACCTL_ADDR_DATA1);
    assign wr_ctrl   = write_hit(req.wr, access_ok, req.addr, dacctl_pkg::DACCTL_ADDR_CTRL);
    assign wr_stop   = write_hit(req.wr, 1'b1, req.addr, dacctl_pkg::DACCTL_ADDR_STOP);

    // Channel data registers
    dacctl_chan_reg u_chan0
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .wr_en   (wr_data0),
        .wdata   (req.wdata),
        .data_q  (data0_q),
        .wrote_q (wrote0_q)
    );

    dacctl_chan_reg u_chan1
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .wr_en   (wr_data1),
        .wdata   (req.wdata),
        .data_q  (data1_q),
        .wrote_q (wrote1_q)
    );

    // Control and stop registers; standby has no effect on contents
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ctrl_q <= dacctl_pkg::DACCTL_CTRL_RST;
            stop_q <= dacctl_pkg::DACCTL_STOP_RST;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= req.wdata[dacctl_pkg::DACCTL_BIT_OE1:dacctl_pkg::DACCTL_BIT_JOINT];
            if (wr_stop)
                stop_q <= req.wdata[0];
        end
    end

    // Enable decode from the held control bits
    assign ch1_oe = ctrl_view[dacctl_pkg::DACCTL_BIT_OE1];
    assign ch0_oe = ctrl_view[dacctl_pkg::DACCTL_BIT_OE0];
    assign joint  = ctrl_view[dacctl_pkg::DACCTL_BIT_JOINT];
    assign conv0  = conv_enable(ch0_oe, ch1_oe, joint);
    assign conv1  = conv_enable(ch1_oe, ch0_oe, joint);

    // Converter drive; output drive follows own enable only
    assign analog_out_ch0 = '{convert: conv0, drive: ch0_oe, restart: wrote0_q && conv0, code: data0_q};
    assign analog_out_ch1 = '{convert: conv1, drive: ch1_oe, restart: wrote1_q && conv1, code: data1_q};
    assign module_stopped = stop_q;

    // Read view; reserved bits fixed high
    assign ctrl_view = {ctrl_q, dacctl_pkg::DACCTL_RSVD_VALUE};
    assign rd_mux = (req.addr == dacctl_pkg::DACCTL_ADDR_STOP)  ? {7'h00, stop_q} :
                    !access_ok                                  ? dacctl_pkg::DACCTL_UNMAPPED_VAL :
                    (req.addr == dacctl_pkg::DACCTL_ADDR_DATA0) ? data0_q :
                    (req.addr == dacctl_pkg::DACCTL_ADDR_DATA1) ? data1_q :
                                                                  ctrl_view;

    // Read data stands for the one cycle after the strobe
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rdata_q <= dacctl_pkg::DACCTL_UNMAPPED_VAL;
        else if (req.rd)
            rdata_q <= rd_mux;
        else
            rdata_q <= dacctl_pkg::DACCTL_UNMAPPED_VAL;
    end
    assign reg_rdata = rdata_q;

    // Checks
    property p_data_write;
        @(posedge clk_sys) disable iff (rst)
        wr_data0 |=> (data0_q == $past(reg_wdata));
    endproperty
    a_data_write: assert property (p_data_write) else $error("data0 not updated");

    property p_drive_code;
        @(posedge clk_sys) disable iff (rst)
        analog_out_ch1.drive |-> (analog_out_ch1.code == data1_q) && analog_out_ch1.convert;
    endproperty
    a_drive_code: assert property (p_drive_code) else $error("ch1 drive without code");

    property p_oe1;
        @(posedge clk_sys) disable iff (rst)
        wr_ctrl |=> (analog_out_ch1.drive == $past(reg_wdata[7]));
    endproperty
    a_oe1: assert property (p_oe1) else $error("ch1 enable wrong");

    property p_oe0;
        @(posedge clk_sys) disable iff (rst)
        wr_ctrl |=> (analog_out_ch0.drive == $past(reg_wdata[6]));
    endproperty
    a_oe0: assert property (p_oe0) else $error("ch0 enable wrong");

    property p_indep;
        @(posedge clk_sys) disable iff (rst)
        !joint |-> (conv0 == ch0_oe) && (conv1 == ch1_oe);
    endproperty
    a_indep: assert property (p_indep) else $error("independent mode wrong");

    property p_joint;
        @(posedge clk_sys) disable iff (rst)
        (wr_ctrl && reg_wdata[5] && (reg_wdata[7] || reg_wdata[6])) |=> conv0 && conv1;
    endproperty
    a_joint: assert property (p_joint) else $error("joint conversion missing");

    property p_own_drive;
        @(posedge clk_sys) disable iff (rst)
        (conv0 && !ch0_oe) |-> !analog_out_ch0.drive;
    endproperty
    a_own_drive: assert property (p_own_drive) else $error("ch0 driven by joint");

    property p_off;
        @(posedge clk_sys) disable iff (rst)
        (wr_ctrl && reg_wdata[7:6] == 2'h0) |=> !conv0 && !conv1;
    endproperty
    a_off: assert property (p_off) else $error("conversion not disabled");

    property p_rsvd;
        @(posedge clk_sys) disable iff (rst)
        (reg_rd && access_ok && reg_addr == dacctl_pkg::DACCTL_ADDR_CTRL) |=> (reg_rdata[4:0] == 5'h1F);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not one");

    property p_standby;
        @(posedge clk_sys) disable iff (rst)
        (standby && !reg_wr) |=> $stable(ctrl_q) && $stable(data0_q) && $stable(data1_q);
    endproperty
    a_standby: assert property (p_standby) else $error("standby changed state");

    property p_restart;
        @(posedge clk_sys) disable iff (rst)
        (wr_data0 && ch0_oe && !wr_ctrl) |=> analog_out_ch0.restart;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart on rewrite");

    property p_stopped;
        @(posedge clk_sys) disable iff (rst)
        (stop_q && reg_wr && reg_addr != dacctl_pkg::DACCTL_ADDR_STOP) |=> $stable(ctrl_q) && $stable(data0_q);
    endproperty
    a_stopped: assert property (p_stopped) else $error("write while stopped");

    // Reset clears both data registers on the following edge
    property p_reset_data;
        @(posedge clk_sys)
        rst |=> (data0_q == dacctl_pkg::DACCTL_DATA_RST) && (data1_q == dacctl_pkg::DACCTL_DATA_RST);
    endproperty
    a_reset_data: assert property (p_reset_data) else $error("data not cleared by reset");

    // Reset leaves all enables clear and the module stopped
    property p_reset_ctrl;
        @(posedge clk_sys)
        rst |=> (ctrl_q == dacctl_pkg::DACCTL_CTRL_RST) && (stop_q == dacctl_pkg::DACCTL_STOP_RST);
    endproperty
    a_reset_ctrl: assert property (p_reset_ctrl) else $error("control not cleared by reset");

    // Channel 1 data lands on the next edge
    property p_data1_write;
        @(posedge clk_sys) disable iff (rst)
        wr_data1 |=> (data1_q == $past(reg_wdata));
    endproperty
    a_data1_write: assert property (p_data1_write) else $error("data1 not updated");

    // Control write lands on the next edge
    property p_ctrl_land;
        @(posedge clk_sys) disable iff (rst)
        wr_ctrl |=> (ctrl_q == $past(reg_wdata[7:5]));
    endproperty
    a_ctrl_land: assert property (p_ctrl_land) else $error("control not updated");

    // Enabled channel 0 converts the value just written
    property p_code0;
        @(posedge clk_sys) disable iff (rst)
        (wr_data0 && ch0_oe) |=> analog_out_ch0.convert && (analog_out_ch0.code == $past(reg_wdata));
    endproperty
    a_code0: assert property (p_code0) else $error("ch0 code not presented");

    // Enabled channel 1 converts the value just written
    property p_code1;
        @(posedge clk_sys) disable iff (rst)
        (wr_data1 && ch1_oe) |=> analog_out_ch1.convert && (analog_out_ch1.code == $past(reg_wdata));
    endproperty
    a_code1: assert property (p_code1) else $error("ch1 code not presented");

    // Joint enable converts channel 1 but leaves its output undriven
    property p_ch1_joint_only;
        @(posedge clk_sys) disable iff (rst)
        (wr_ctrl && reg_wdata[5] && reg_wdata[6] && !reg_wdata[7]) |=> analog_out_ch1.convert && !analog_out_ch1.drive;
    endproperty
    a_ch1_joint_only: assert property (p_ch1_joint_only) else $error("ch1 joint drive wrong");

    // Joint enable converts channel 0 but leaves its output undriven
    property p_ch0_joint_only;
        @(posedge clk_sys) disable iff (rst)
        (wr_ctrl && reg_wdata[5] && reg_wdata[7] && !reg_wdata[6]) |=> analog_out_ch0.convert && !analog_out_ch0.drive;
    endproperty
    a_ch0_joint_only: assert property (p_ch0_joint_only) else $error("ch0 joint drive wrong");

    // Rewrite of converting channel 1 restarts it
    property p_restart1;
        @(posedge clk_sys) disable iff (rst)
        (wr_data1 && conv1) |=> analog_out_ch1.restart;
    endproperty
    a_restart1: assert property (p_restart1) else $error("no ch1 restart on rewrite");

    // Idle channel never restarts on a rewrite
    property p_idle_no_restart;
        @(posedge clk_sys) disable iff (rst)
        (wr_data1 && !conv1) |=> !analog_out_ch1.restart;
    endproperty
    a_idle_no_restart: assert property (p_idle_no_restart) else $error("idle ch1 restarted");

    // Restart only follows a data write
    property p_restart_needs_write;
        @(posedge clk_sys) disable iff (rst)
        !wr_data0 |=> !analog_out_ch0.restart;
    endproperty
    a_restart_needs_write: assert property (p_restart_needs_write) else $error("ch0 restart without write");

    // Read data are zero outside the answer cycle
    property p_rd_idle;
        @(posedge clk_sys) disable iff (rst)
        !reg_rd |=> (reg_rdata == dacctl_pkg::DACCTL_UNMAPPED_VAL);
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without strobe");

    // Gated registers read as zero while stopped
    property p_stopped_read;
        @(posedge clk_sys) disable iff (rst)
        (reg_rd && stop_q && reg_addr != dacctl_pkg::DACCTL_ADDR_STOP) |=> (reg_rdata == 8'h00);
    endproperty
    a_stopped_read: assert property (p_stopped_read) else $error("read while stopped");

    // Stop register stays readable at all times
    property p_stop_read;
        @(posedge clk_sys) disable iff (rst)
        (reg_rd && reg_addr == dacctl_pkg::DACCTL_ADDR_STOP) |=> (reg_rdata == {7'h00, $past(stop_q)});
    endproperty
    a_stop_read: assert property (p_stop_read) else $error("stop register read wrong");

    // Data 0 read returns the stored value
    property p_data0_readback;
        @(posedge clk_sys) disable iff (rst)
        (reg_rd && access_ok && reg_addr == dacctl_pkg::DACCTL_ADDR_DATA0) |=> (reg_rdata == $past(data0_q));
    endproperty
    a_data0_readback: assert property (p_data0_readback) else $error("data0 read wrong");

    // Channel 1 data ignore writes while stopped
    property p_stopped1;
        @(posedge clk_sys) disable iff (rst)
        (stop_q && reg_wr && reg_addr != dacctl_pkg::DACCTL_ADDR_STOP) |=> $stable(data1_q);
    endproperty
    a_stopped1: assert property (p_stopped1) else $error("data1 write while stopped");

    // Standby keeps conversion and drive unchanged
    property p_standby_conv;
        @(posedge clk_sys) disable iff (rst)
        (standby && !reg_wr) |=> $stable(conv0) && $stable(conv1) && $stable(ch0_oe) && $stable(ch1_oe);
    endproperty
    a_standby_conv: assert property (p_standby_conv) else $error("standby changed conversion");

endmodule

// ---- src/dacctl_pkg.sv ----
// Package: register map, field positions, reset values and carrier types for the DAC control block
package dacctl_pkg;

    // Register indices on the byte-wide port
    localparam logic [1:0] DACCTL_ADDR_DATA0 = 2'h0;
    localparam logic [1:0] DACCTL_ADDR_DATA1 = 2'h1;
    localparam logic [1:0] DACCTL_ADDR_CTRL  = 2'h2;
    localparam logic [1:0] DACCTL_ADDR_STOP  = 2'h3;

    // Control register field positions
    localparam int DACCTL_BIT_OE1 = 7;
    localparam int DACCTL_BIT_OE0 = 6;
    localparam int DACCTL_BIT_JOINT = 5;

    // Reset values
    localparam logic [7:0] DACCTL_DATA_RST     = 8'h00;
    localparam logic [2:0] DACCTL_CTRL_RST     = 3'h0;
    localparam logic [4:0] DACCTL_RSVD_VALUE   = 5'h1F;
    localparam logic       DACCTL_STOP_RST     = 1'b1;
    localparam logic [7:0] DACCTL_UNMAPPED_VAL = 8'h00;

    // Software read/write request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [1:0] addr;
        logic [7:0] wdata;
    } dacctl_req_t;

    // Per-channel converter drive
    typedef struct packed {
        logic       convert;
        logic       drive;
        logic       restart;
        logic [7:0] code;
    } dacctl_chan_t;

endpackage

// ---- src/dacctl_chan_reg.sv ----
// One channel's data register with restart pulse on rewrite
module dacctl_chan_reg
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       wr_en,
    input  wire logic [7:0] wdata,
    output logic      [7:0] data_q,
    output logic            wrote_q
);

    // Data holds through standby; only reset or a write changes it
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            data_q  <= dacctl_pkg::DACCTL_DATA_RST;
            wrote_q <= 1'b0;
        end
        else
        begin
            wrote_q <= wr_en;
            if (wr_en)
                data_q <= wdata;
        end
    end

endmodule

// ---- bench/tb_dacctl_top.sv ----
// Testbench: register access, enable decode and restart checks for the DAC control block
module tb_dacctl_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                     clk_sys = 1'b0;
    logic                     rst = 1'b1;
    logic [1:0]               reg_addr = 2'h0;
    logic [7:0]               reg_wdata = 8'h00;
    logic                     reg_wr = 1'b0;
    logic                     reg_rd = 1'b0;
    logic [7:0]               reg_rdata;
    logic                     standby = 1'b0;
    dacctl_pkg::dacctl_chan_t ch0;
    dacctl_pkg::dacctl_chan_t ch1;
    logic                     module_stopped;
    int                       n_fail = 0;
    int                       tests_run = 0;
    logic [2:0]               e;

    // 200 MHz system clock
    always #2.5 clk_sys = ~clk_sys;

    dacctl_top u_dut
    (
        .clk_sys        (clk_sys),
        .rst            (rst),
        .reg_addr       (reg_addr),
        .reg_wdata      (reg_wdata),
        .reg_wr         (reg_wr),
        .reg_rd         (reg_rd),
        .reg_rdata      (reg_rdata),
        .standby        (standby),
        .analog_out_ch0 (ch0),
        .analog_out_ch1 (ch1),
        .module_stopped (module_stopped)
    );

    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write; returns just after the taking edge has landed
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask

    // One-cycle read; data only stand in the cycle after the strobe
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    // Single exit point for both normal end and watchdog
    task automatic wrap_up();
        $display("Checks run %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Watchdog well beyond the roughly 120 cycles the sequence needs
    initial
    begin
        repeat (3000) @(posedge clk_sys);
        n_fail++;
        wrap_up();
    end

    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk({7'h00, module_stopped}, 8'h01);
        wr(2'h0, 8'h77);
        rd(2'h0, 8'h00);
        rd(2'h2, 8'h00);
        rd(2'h3, 8'h01);
        wr(2'h3, 8'h00);
        chk({7'h00, module_stopped}, 8'h00);
        rd(2'h3, 8'h00);
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h00);
        rd(2'h2, 8'h1F);
        wr(2'h2, 8'hFF);
        rd(2'h2, 8'hFF);
        wr(2'h2, 8'h00);
        rd(2'h2, 8'h1F);
        wr(2'h0, 8'h55);
        wr(2'h1, 8'hAA);
        rd(2'h0, 8'h55);
        rd(2'h1, 8'hAA);
        // All eight enable combinations, order {oe1, oe0, joint}
        for (int i = 0; i < 8; i++)
        begin
            e = i[2:0];
            wr(2'h2, {e, 5'h00});
            chk({6'h00, ch1.convert, ch0.convert}, {6'h00, e[2] | e[0] & e[1], e[1] | e[0] & e[2]});
            chk({6'h00, ch1.drive, ch0.drive}, {6'h00, e[2:1]});
            chk(ch0.code, 8'h55);
            chk(ch1.code, 8'hAA);
            rd(2'h2, {e, 5'h1F});
        end
        // Rewrite while converting restarts; idle channel must not
        wr(2'h2, 8'h40);
        wr(2'h0, 8'h33);
        chk({6'h00, ch1.restart, ch0.restart}, 8'h01);
        chk(ch0.code, 8'h33);
        @(posedge clk_sys);
        #1;
        chk({6'h00, ch1.restart, ch0.restart}, 8'h00);
        wr(2'h1, 8'h11);
        chk({6'h00, ch1.restart, ch0.restart}, 8'h00);
        // Channel 1 alone enabled: its rewrite restarts it
        wr(2'h2, 8'h80);
        wr(2'h1, 8'h22);
        chk({6'h00, ch1.restart, ch0.restart}, 8'h02);
        chk(ch1.code, 8'h22);
        // Standby must leave registers and conversion in place
        @(posedge clk_sys);
        standby <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(2'h0, 8'h33);
        rd(2'h2, 8'h9F);
        chk({6'h00, ch1.convert, ch0.convert}, 8'h02);
        // Mid-run reset clears data and stops the module again
        @(posedge clk_sys);
        rst     <= 1'b1;
        standby <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk({7'h00, module_stopped}, 8'h01);
        chk({6'h00, ch1.convert, ch0.convert}, 8'h00);
        wr(2'h1, 8'h99);
        rd(2'h3, 8'h01);
        wr(2'h3, 8'h00);
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h00);
        rd(2'h2, 8'h1F);
        wrap_up();
    end
endmodule
